// [core/periph_clock_select.sv]
// Peripheral clock select block with its APB register file and the
// plain storage of the timer group registers that share its map.
// Assumes an APB master on pclk; all ticks are enables on pclk.
`include "clock_select_cfg.svh"
module periph_clock_select #(
    parameter int ADDR_WIDTH = 14
) (
    // Clock and reset.
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave.
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_WIDTH-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Sources offered to the clock output by the two select bits.
    input  wire logic [3:0]            clock_output_sources,
    // Rate enables to the peripheral groups.
    output logic                       timer_clock_tick,
    output logic                       i2c_clock_tick,
    output logic                       serial_clock_tick,
    output logic                       clock_output_tick,
    // Current selections, for the peripherals that decode them.
    output logic                       timer_clock_full,
    output logic                       serial_clock_full
);

    ////////////////////////////////////////////////////////////////////////
    // Storage map helpers.

    // Index of each plain storage slot; the wide ones come first.
    function automatic logic [11:0] store_index(input int slot);
        logic [11:0] idx;
        idx = 12'h000;
        case (slot)
            0:  idx = `IDX_TIMER1_RELOAD;
            1:  idx = `IDX_TIMER2_RELOAD;
            2:  idx = `IDX_TIMER4_RELOAD;
            3:  idx = `IDX_TIMER0_COUNT;
            4:  idx = `IDX_TIMER1_COUNT;
            5:  idx = `IDX_TIMER2_COUNT;
            6:  idx = `IDX_TIMER3_COUNT;
            7:  idx = `IDX_TIMER4_COUNT;
            8:  idx = `IDX_COUNT_SOURCE_ZERO;
            9:  idx = `IDX_COUNT_SOURCE_ONE;
            10: idx = `IDX_COUNT_SOURCE_TWO;
            11: idx = `IDX_PWM_FUNCTION;
            12: idx = `IDX_WAVEFORM_OUTPUT;
            13: idx = `IDX_WAVEFORM_CHANGE;
            14: idx = `IDX_COUNT_START;
            15: idx = `IDX_ONE_SHOT_START;
            16: idx = `IDX_TRIGGER_SELECT;
            17: idx = `IDX_UP_DOWN;
            18: idx = `IDX_TIMER0_MODE;
            19: idx = `IDX_TIMER1_MODE;
            default: idx = 12'h000;
        endcase
        return idx;
    endfunction : store_index

    // Byte-lane mask applied to a write of a slot of the given width.
    function automatic logic [15:0] lane_mask(input logic       wide,
                                              input logic [3:0] strb);
        logic [15:0] mask;
        mask = {{8{strb[1] & wide}}, {8{strb[0]}}};
        return mask;
    endfunction : lane_mask

    ////////////////////////////////////////////////////////////////////////
    // APB address decode.

    localparam int NSTORE = `STORE_COUNT;

    logic [11:0] word_index;
    logic        aligned;
    logic        setup_phase;
    logic        write_commit;
    logic        hit_select;
    logic        hit_protect;
    logic        hit_control;
    logic        hit_mode_hi;
    logic        hit_mode_top;
    logic        hit_any;
    logic [NSTORE-1:0] hit_store;

    // The word index ignores the two byte bits, which must be zero.
    assign word_index   = 12'(paddr[ADDR_WIDTH-1:2]);
    assign aligned      = (paddr[1:0] == 2'b00);
    assign setup_phase  = psel & ~penable;
    assign write_commit = psel & penable & pready & pwrite;

    // Fixed registers decode by index.
    assign hit_select  = aligned &
                         (word_index == `IDX_PERIPH_CLOCK_SELECT);
    assign hit_protect = aligned & (word_index == `IDX_PROTECT);
    assign hit_control = aligned &
                         (word_index == `IDX_SYSTEM_CLOCK_CONTROL);
    assign hit_mode_hi  = aligned & (word_index == `IDX_TIMER2_MODE);
    assign hit_mode_top = aligned &
                          ((word_index == `IDX_TIMER3_MODE) |
                           (word_index == `IDX_TIMER4_MODE));

    // One comparator per storage slot.
    genvar g;
    generate
        for (g = 0; g < NSTORE; g++) begin : g_decode
            assign hit_store[g] = aligned &
                                  (word_index == store_index(g));
        end
    endgenerate

    assign hit_any = hit_select | hit_protect | hit_control |
                     hit_mode_hi | hit_mode_top | (|hit_store);

    ////////////////////////////////////////////////////////////////////////
    // Control registers.

    logic [7:0] select_reg;
    logic [7:0] select_next;
    logic [7:0] protect_reg;
    logic [7:0] control_reg;
    logic [7:0] mode_extra_reg [3];
    logic       select_write;

    // A locked select register simply keeps its value; the bus still
    // completes without error so software cannot tell from the answer.
    assign select_write = write_commit & hit_select & pstrb[0] &
                          protect_reg[`BIT_CLOCK_WRITE_ENABLE];
    assign select_next  = select_write ? pwdata[7:0] : select_reg;

    // Reserved bits are kept as written and steer nothing.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            select_reg <= `RESET_PERIPH_CLOCK_SELECT;
        end else begin
            select_reg <= select_next;
        end
    end

    // Protect and control zero are ordinary byte registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            protect_reg <= `RESET_PROTECT;
            control_reg <= `RESET_SYSTEM_CLOCK_CTRL;
        end else begin
            if (write_commit & hit_protect & pstrb[0]) begin
                protect_reg <= pwdata[7:0];
            end
            if (write_commit & hit_control & pstrb[0]) begin
                control_reg <= pwdata[7:0];
            end
        end
    end

    // The last three mode registers live outside the storage slots.
    logic [1:0] mode_slot;
    assign mode_slot = hit_mode_hi ? 2'd0 :
                       (word_index == `IDX_TIMER3_MODE) ? 2'd1 : 2'd2;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_extra_reg[0] <= 8'h00;
            mode_extra_reg[1] <= 8'h00;
            mode_extra_reg[2] <= 8'h00;
        end else if (write_commit & (hit_mode_hi | hit_mode_top) &
                     pstrb[0]) begin
            mode_extra_reg[mode_slot] <= pwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Plain storage for the timer group registers.

    logic [15:0] store_reg [NSTORE];
    logic [15:0] store_read;

    // Each slot honours its byte lanes; narrow slots ignore lane one.
    generate
        for (g = 0; g < NSTORE; g++) begin : g_store
            localparam logic WIDE = (g < `STORE_WIDE_COUNT);
            logic [15:0] mask;
            assign mask = lane_mask(WIDE, pstrb);
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    store_reg[g] <= `RESET_STORE;
                end else if (write_commit & hit_store[g]) begin
                    store_reg[g] <= (store_reg[g] & ~mask) |
                                    (pwdata[15:0] & mask);
                end
            end
        end
    endgenerate

    // One-hot select of the addressed slot.
    always_comb begin
        store_read = 16'h0000;
        for (int s = 0; s < NSTORE; s++) begin
            if (hit_store[s]) begin
                store_read = store_reg[s];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data and answer.

    logic [31:0] read_value;
    clock_select_pkg::apb_phase_type phase_reg;
    clock_select_pkg::apb_phase_type phase_next;

    // Unmapped addresses read zero and answer with an error.
    assign read_value =
        hit_select   ? {24'h000000, select_reg}  :
        hit_protect  ? {24'h000000, protect_reg} :
        hit_control  ? {24'h000000, control_reg} :
        (hit_mode_hi | hit_mode_top) ?
                       {24'h000000, mode_extra_reg[mode_slot]} :
                       {16'h0000, store_read};

    // No wait state; read data still comes from a flip-flop loaded at setup.
    always_comb begin
        phase_next = phase_reg;
        case (phase_reg)
            clock_select_pkg::PHASE_IDLE: begin
                if (setup_phase) begin
                    phase_next = clock_select_pkg::PHASE_ANSWER;
                end
            end
            clock_select_pkg::PHASE_ANSWER: begin
                phase_next = clock_select_pkg::PHASE_IDLE;
            end
            default: phase_next = clock_select_pkg::PHASE_IDLE;
        endcase
    end

    // Answer registers load on the setup edge and clear after access.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg <= clock_select_pkg::PHASE_IDLE;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            prdata    <= 32'h00000000;
        end else begin
            phase_reg <= phase_next;
            pready    <= (phase_next == clock_select_pkg::PHASE_ANSWER);
            if (setup_phase) begin
                pslverr <= ~hit_any;
                prdata  <= (pwrite | ~hit_any) ? 32'h00000000 : read_value;
            end else if (pready) begin
                pslverr <= 1'b0;
                prdata  <= 32'h00000000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Rate selection.

    logic half_tick;
    logic output_tick;
    clock_select_pkg::clock_source_type timer_source;
    clock_select_pkg::clock_source_type serial_source;

    // Half-rate enable shared by the timer, i2c and serial groups.
    clock_rate_divider #(
        .DIVIDE (`HALF_CLOCK_DIVIDE)
    ) u_half_rate (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (half_tick)
    );

    // Clock output routing.
    clock_output_select u_output_select (
        .expand       (select_reg[`BIT_CLOCK_OUTPUT_EXPAND]),
        .source_sel   ({control_reg[`BIT_CLOCK_OUTPUT_SEL_HI],
                        control_reg[`BIT_CLOCK_OUTPUT_SEL_LO]}),
        .source_ticks (clock_output_sources),
        .full_tick    (1'b1),
        .out_tick     (output_tick)
    );

    assign timer_source  = clock_select_pkg::clock_source_type'(
                               select_reg[`BIT_TIMER_CLOCK_SELECT]);
    assign serial_source = clock_select_pkg::clock_source_type'(
                               select_reg[`BIT_SERIAL_CLOCK_SELECT]);

    // The full rate is an enable held high; switching mid-period can
    // shorten one half-rate interval, which the peripherals tolerate.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_clock_tick  <= 1'b0;
            i2c_clock_tick    <= 1'b0;
            serial_clock_tick <= 1'b0;
            clock_output_tick <= 1'b0;
            timer_clock_full  <= 1'b1;
            serial_clock_full <= 1'b1;
        end else begin
            timer_clock_tick  <= (timer_source ==
                                  clock_select_pkg::SOURCE_FULL) |
                                 half_tick;
            i2c_clock_tick    <= (timer_source ==
                                  clock_select_pkg::SOURCE_FULL) |
                                 half_tick;
            serial_clock_tick <= (serial_source ==
                                  clock_select_pkg::SOURCE_FULL) |
                                 half_tick;
            clock_output_tick <= output_tick;
            timer_clock_full  <= select_reg[`BIT_TIMER_CLOCK_SELECT];
            serial_clock_full <= select_reg[`BIT_SERIAL_CLOCK_SELECT];
        end
    end

endmodule : periph_clock_select

// [pkg/clock_select_cfg.svh]
// Address map, field positions, reset values and timing counts for the
// peripheral clock select block. Assumes APB with 32-bit data.
`ifndef CLOCK_SELECT_CFG_SVH
`define CLOCK_SELECT_CFG_SVH

// Register indexes; the byte address is four times the index.
`define IDX_PERIPH_CLOCK_SELECT   12'h012
`define IDX_PROTECT               12'h00A
`define IDX_SYSTEM_CLOCK_CONTROL  12'h00C
`define IDX_COUNT_SOURCE_ZERO     12'h1D0
`define IDX_COUNT_SOURCE_ONE      12'h1D1
`define IDX_COUNT_SOURCE_TWO      12'h1D2
`define IDX_PWM_FUNCTION          12'h1D4
`define IDX_WAVEFORM_OUTPUT       12'h1D5
`define IDX_WAVEFORM_CHANGE       12'h1D8
`define IDX_TIMER1_RELOAD         12'h302
`define IDX_TIMER2_RELOAD         12'h304
`define IDX_TIMER4_RELOAD         12'h306
`define IDX_COUNT_START           12'h320
`define IDX_ONE_SHOT_START        12'h322
`define IDX_TRIGGER_SELECT        12'h323
`define IDX_UP_DOWN               12'h324
`define IDX_TIMER0_COUNT          12'h326
`define IDX_TIMER1_COUNT          12'h328
`define IDX_TIMER2_COUNT          12'h32A
`define IDX_TIMER3_COUNT          12'h32C
`define IDX_TIMER4_COUNT          12'h32E
`define IDX_TIMER0_MODE           12'h336
`define IDX_TIMER1_MODE           12'h337
`define IDX_TIMER2_MODE           12'h338
`define IDX_TIMER3_MODE           12'h339
`define IDX_TIMER4_MODE           12'h33A

// Number of plain storage registers and how many of them are 16 bits.
`define STORE_COUNT               20
`define STORE_WIDE_COUNT          8

// Field positions.
`define BIT_TIMER_CLOCK_SELECT    0
`define BIT_SERIAL_CLOCK_SELECT   1
`define BIT_CLOCK_OUTPUT_EXPAND   5
`define BIT_CLOCK_WRITE_ENABLE    0
`define BIT_CLOCK_OUTPUT_SEL_LO   0
`define BIT_CLOCK_OUTPUT_SEL_HI   1

// Reset values.
`define RESET_PERIPH_CLOCK_SELECT 8'h03
`define RESET_PROTECT             8'h00
`define RESET_SYSTEM_CLOCK_CTRL   8'h00
`define RESET_STORE               16'h0000

// Timing: divide ratio of the half-rate clock, and a wait-state count the slave does not use (it answers with none).
`define HALF_CLOCK_DIVIDE         2
`define APB_WAIT_STATES           1

`endif

// [pkg/clock_select_pkg.sv]
// Types shared by the peripheral clock select block.
// Assumes the constants header is compiled alongside.
package clock_select_pkg;

    // Phase of the APB slave answer sequence.
    typedef enum logic [0:0] {
        PHASE_IDLE,
        PHASE_ANSWER
    } apb_phase_type;

    // Which of the two rates feeds a peripheral group.
    typedef enum logic [0:0] {
        SOURCE_HALF,
        SOURCE_FULL
    } clock_source_type;

endpackage : clock_select_pkg

// [core/clock_rate_divider.sv]
// Makes a one-cycle enable pulse every DIVIDE cycles of pclk.
// Assumes a single free-running clock and an asynchronous low reset.
module clock_rate_divider #(
    parameter int DIVIDE = 2
) (
    // Clock and reset.
    input  wire logic pclk,
    input  wire logic presetn,
    // Divided enable.
    output logic      tick
);

    localparam int CW = (DIVIDE > 2) ? $clog2(DIVIDE) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);

    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;
    logic          wrap;

    // The pulse fires on the last count so the first one follows reset late.
    assign wrap       = (count_reg == LAST);
    assign count_next = wrap ? '0 : count_reg + CW'(1);

    // Counter and registered pulse.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= '0;
            tick      <= 1'b0;
        end else begin
            count_reg <= count_next;
            tick      <= wrap;
        end
    end

endmodule : clock_rate_divider

// [core/clock_output_select.sv]
// Chooses the enable that drives the clock output function.
// Assumes all source ticks come from logic on pclk.
module clock_output_select (
    // Selection.
    input  wire logic       expand,
    input  wire logic [1:0] source_sel,
    // Candidate ticks.
    input  wire logic [3:0] source_ticks,
    input  wire logic       full_tick,
    // Chosen tick.
    output logic            out_tick
);

    logic routed_tick;

    // Expansion overrides the two-bit selection with the undivided rate.
    assign routed_tick = source_ticks[source_sel];
    assign out_tick    = expand ? full_tick : routed_tick;

endmodule : clock_output_select

// [verification/periph_clock_select_asserts.sv]
// Concurrent checks on the ports of the peripheral clock select block.
// Assumes one clock, pclk, and the active-low asynchronous presetn.
`include "clock_select_cfg.svh"
module periph_clock_select_asserts #(
    parameter int ADDR_WIDTH = 14
) (
    // Clock and reset.
    input wire logic                  pclk,
    input wire logic                  presetn,
    // APB slave.
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [3:0]            pstrb,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    // Clock output candidates.
    input wire logic [3:0]            clock_output_sources,
    // Rate enables and selections.
    input wire logic                  timer_clock_tick,
    input wire logic                  i2c_clock_tick,
    input wire logic                  serial_clock_tick,
    input wire logic                  clock_output_tick,
    input wire logic                  timer_clock_full,
    input wire logic                  serial_clock_full
);
    localparam logic [13:0] PROT_ADDR = {`IDX_PROTECT, 2'b00};
    localparam logic [13:0] SEL_ADDR  = {`IDX_PERIPH_CLOCK_SELECT, 2'b00};

    ////////////////////////////////////////////////////////////////////////
    // Shadows of the protect bit and the expansion bit, seen from the bus.
    logic commit;
    logic sel_hit;
    logic prot_hit;
    logic prot_reg;
    logic expand_reg;
    assign commit   = psel && penable && pready && pwrite && pstrb[0];
    assign sel_hit  = commit && !pslverr && (paddr == ADDR_WIDTH'(SEL_ADDR));
    assign prot_hit = commit && !pslverr && (paddr == ADDR_WIDTH'(PROT_ADDR));

    // A blocked write must not move the shadow, or the checks would drift.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prot_reg   <= 1'b0;
            expand_reg <= 1'b0;
        end else begin
            if (prot_hit) prot_reg <= pwdata[0];
            if (sel_hit && prot_reg) expand_reg <= pwdata[5];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking main_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Rates settle within four cycles of a selection change.
    AST_RESET_VALUES: assert property (disable iff (1'b0) !presetn |->
        timer_clock_full && serial_clock_full && !timer_clock_tick && !pready)
        else $error("outputs not at reset values during reset");
    AST_TIMER_FULL: assert property (timer_clock_full [*4]
        |-> timer_clock_tick) else $error("timer tick gap at full rate");
    AST_TIMER_HALF: assert property (!timer_clock_full [*4]
        |-> timer_clock_tick != $past(timer_clock_tick))
        else $error("timer tick not alternating at half rate");
    AST_I2C_SAME: assert property (i2c_clock_tick == timer_clock_tick)
        else $error("i2c tick differs from timer tick");
    AST_SERIAL_FULL: assert property (serial_clock_full [*4]
        |-> serial_clock_tick) else $error("serial tick gap at full rate");
    AST_SERIAL_HALF: assert property (!serial_clock_full [*4]
        |-> serial_clock_tick != $past(serial_clock_tick))
        else $error("serial tick not alternating at half rate");
    AST_EXPAND_FULL: assert property (expand_reg [*4]
        |-> clock_output_tick) else $error("expanded output not full rate");
    AST_PROTECT_DROP: assert property (sel_hit && !prot_reg |=>
        ($stable(timer_clock_full) && $stable(serial_clock_full)) [*3])
        else $error("protected write changed the selection");
    AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
        else $error("no answer one cycle after setup");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
endmodule : periph_clock_select_asserts

bind periph_clock_select periph_clock_select_asserts #(
    .ADDR_WIDTH(ADDR_WIDTH)
) i_asserts (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clock_output_sources(clock_output_sources),
    .timer_clock_tick(timer_clock_tick), .i2c_clock_tick(i2c_clock_tick),
    .serial_clock_tick(serial_clock_tick),
    .clock_output_tick(clock_output_tick),
    .timer_clock_full(timer_clock_full), .serial_clock_full(serial_clock_full)
);

// [verification/periph_clock_select_test.sv]
// Self-checking bench for the peripheral clock select block.
// Assumes the design, its header and the bound checker are compiled first.
`include "clock_select_cfg.svh"
module periph_clock_select_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk = 1'b0;
    logic        presetn = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [13:0] paddr = 14'h0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0]  pstrb = 4'hF;
    logic [3:0]  clock_output_sources = 4'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        timer_clock_tick;
    logic        i2c_clock_tick;
    logic        serial_clock_tick;
    logic        clock_output_tick;
    logic        timer_clock_full;
    logic        serial_clock_full;
    int          n_mismatch = 0;
    int          tests_run = 0;
    int          seed = 85641;

    // Free-running 100 MHz clock.
    always #5 pclk = ~pclk;

    periph_clock_select #(.ADDR_WIDTH(14)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .clock_output_sources(clock_output_sources),
        .timer_clock_tick(timer_clock_tick), .i2c_clock_tick(i2c_clock_tick),
        .serial_clock_tick(serial_clock_tick),
        .clock_output_tick(clock_output_tick),
        .timer_clock_full(timer_clock_full),
        .serial_clock_full(serial_clock_full)
    );

    ////////////////////////////////////////////////////////////////////////
    // Expected values: eight ticks in eight cycles at full rate, four at half.
    function automatic logic [31:0] exp_ticks(input logic full);
        return full ? 32'h0000_0008 : 32'h0000_0004;
    endfunction : exp_ticks

    function automatic logic [31:0] exp_out(input logic expand, input int sel,
                                            input logic [3:0] pat);
        return expand ? 32'h0000_0001 : {31'h0, pat[sel]};
    endfunction : exp_out

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    // One APB transfer; the request holds until pready is seen at an edge.
    task automatic apb(input logic wr, input logic [11:0] idx,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) check("pready wait", 32'h1, 32'h0);
    endtask : apb

    task automatic wr(input logic [11:0] idx, input logic [31:0] wd);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, idx, wd, rd, err);
    endtask : wr

    task automatic rd_check(input string what, input logic [11:0] idx,
                            input logic [31:0] exp, input logic exp_err);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, idx, 32'h0, rd, err);
        check(what, exp, rd);
        check("pslverr", {31'h0, exp_err}, {31'h0, err});
    endtask : rd_check

    // Counts the rate enables over eight sampled edges.
    task automatic count_ticks(output logic [31:0] t, output logic [31:0] c,
                               output logic [31:0] s);
        t = 0;
        c = 0;
        s = 0;
        repeat (8) begin
            @(posedge pclk);
            if (timer_clock_tick === 1'b1) t++;
            if (i2c_clock_tick === 1'b1) c++;
            if (serial_clock_tick === 1'b1) s++;
        end
    endtask : count_ticks

    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up

    ////////////////////////////////////////////////////////////////////////
    // The run needs about 430 cycles; the 20000-cycle limit leaves wide margin.
    initial begin
        #200000;
        n_mismatch++;
        wrap_up();
    end

    // Main sequence.
    initial begin
        logic [31:0] v;
        logic [31:0] t;
        logic [31:0] c;
        logic [31:0] s;
        logic [3:0]  pat;
        // Reset falls at time zero so every output is known at the first edge.
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        check("timer full", 32'h1, {31'h0, timer_clock_full});
        presetn <= 1'b1;
        rd_check("select", `IDX_PERIPH_CLOCK_SELECT, 32'h3, 1'b0);
        rd_check("mode", `IDX_TIMER0_MODE, 32'h0, 1'b0);
        rd_check("start flags", `IDX_COUNT_START, 32'h0, 1'b0);
        rd_check("unmapped", 12'h015, 32'h0, 1'b1);
        wr(`IDX_PERIPH_CLOCK_SELECT, 32'h0000_0000);
        rd_check("locked", `IDX_PERIPH_CLOCK_SELECT, 32'h3, 1'b0);
        wr(`IDX_PROTECT, 32'h0000_0001);
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 32'h0 : (i == 1) ? 32'hFF :
                ($random(seed) & 32'hFF);
            wr(`IDX_PERIPH_CLOCK_SELECT, v);
            rd_check("select", `IDX_PERIPH_CLOCK_SELECT, v, 1'b0);
            repeat (4) @(posedge pclk);
            check("timer full", {31'h0, v[0]},
                  {31'h0, timer_clock_full});
            check("serial full", {31'h0, v[1]},
                  {31'h0, serial_clock_full});
            count_ticks(t, c, s);
            check("timer ticks", exp_ticks(v[0]), t);
            check("i2c ticks", exp_ticks(v[0]), c);
            check("serial ticks", exp_ticks(v[1]), s);
            for (int sel = 0; sel < 4; sel++) begin
                wr(`IDX_SYSTEM_CLOCK_CONTROL, sel);
                pat = $random(seed);
                clock_output_sources <= pat;
                repeat (4) @(posedge pclk);
                check("clock out", exp_out(v[5], sel, pat),
                      clock_output_tick);
            end
        end
        wr(`IDX_PROTECT, 32'h0000_0000);
        wr(`IDX_PERIPH_CLOCK_SELECT, ~v & 32'hFF);
        rd_check("locked", `IDX_PERIPH_CLOCK_SELECT, v, 1'b0);
        v = $random(seed) & 32'hFFFF;
        wr(`IDX_TIMER0_COUNT, v);
        rd_check("count", `IDX_TIMER0_COUNT, v, 1'b0);
        wr(`IDX_TIMER3_MODE, 32'h0000_00A5);
        rd_check("mode three", `IDX_TIMER3_MODE, 32'hA5, 1'b0);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd_check("select", `IDX_PERIPH_CLOCK_SELECT, 32'h3, 1'b0);
        wrap_up();
    end
endmodule : periph_clock_select_test
